// [logic/pmicsc_pkg.sv]
/*
 * Constants for the status and configuration register slice: command codes,
 * bit positions, reset values and the wake deglitch time.
 * Assumes a 100 MHz register clock and a serial command decoder upstream.
 */
package pmicsc_pkg;

    // ------------------------------------------------------------
    // Clock and deglitch timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int WAKE_DEGLITCH_NS = 1000;
    localparam int WAKE_DEGLITCH_CYC = (WAKE_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DGL_CNT_W = 8;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RD_STATUS_TWO = 8'h10;
    localparam logic [7:0] CMD_RD_RAIL_CFG = 8'h11;
    localparam logic [7:0] CMD_RD_THERM_CFG = 8'h12;
    localparam logic [7:0] CMD_WR_RAIL_CFG = 8'h21;
    localparam logic [7:0] CMD_WR_THERM_CFG = 8'h22;
    localparam logic [7:0] CMD_CLR_RESUME_LATCH = 8'h30;
    localparam logic [7:0] CLR_RESUME_DATA = 8'h8E;

    // ------------------------------------------------------------
    // Register layouts and reset values
    // ------------------------------------------------------------
    localparam logic CFG_UNLOCKED = 1'b0;
    localparam logic [7:0] STATUS_TWO_RESET = 8'h00;
    localparam logic [7:0] RAIL_CFG_RESET = 8'h0B;
    localparam logic [7:0] THERM_CFG_RESET = 8'h00;
    localparam logic [7:0] THERM_CFG_WR_MASK = 8'h0B;
    localparam logic [7:0] RAIL_OV_MASK = 8'hB0;
    localparam logic [7:0] RAIL_UV_MASK = 8'h0B;
    localparam logic [7:0] RD_DATA_RESET = 8'h00;

    localparam int STAT_ERR_BIT = 2;
    localparam int STAT_WAKE_L_BIT = 1;
    localparam int STAT_WAKE_BIT = 0;

    localparam int RAIL_CNT = 3;
    localparam int OV_POS_ONE = 4;
    localparam int OV_POS_TWO = 5;
    localparam int OV_POS_STEPUP = 7;
    localparam int UV_POS_ONE = 0;
    localparam int UV_POS_TWO = 1;
    localparam int UV_POS_STEPUP = 3;
    localparam int OT_POS_ONE = 0;
    localparam int OT_POS_TWO = 1;
    localparam int OT_POS_STEPUP = 3;

    // Packed layout of synchronised analog and pin inputs
    localparam int ASYNC_W = 10;
    localparam int ASYNC_OV_LSB = 0;
    localparam int ASYNC_UV_LSB = 3;
    localparam int ASYNC_OT_LSB = 6;
    localparam int ASYNC_ERR_POS = 9;

endpackage

// [logic/pmicsc_deglitch.sv]
/*
 * Wake pin synchroniser and deglitch filter.
 * Assumes an asynchronous pin; output changes only after the pin holds its
 * new level for the full deglitch time.
 */
`timescale 1ns/1ns
module pmicsc_deglitch
    import pmicsc_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic pin_i,
    output logic level_o
);

    logic sync1_q, sync1_d;
    logic sync2_q, sync2_d;
    logic level_q, level_d;
    logic [DGL_CNT_W-1:0] cnt_q, cnt_d;

    // ------------------------------------------------------------
    // Filter
    // ------------------------------------------------------------
    always_comb
    begin
        sync1_d = pin_i;
        sync2_d = sync1_q;
        level_d = level_q;
        cnt_d = '0;
        if (sync2_q != level_q)
        begin
            if (cnt_q == DGL_CNT_W'(WAKE_DEGLITCH_CYC - 1))
            begin
                level_d = sync2_q;
            end
            else
            begin
                cnt_d = cnt_q + DGL_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            level_q <= 1'b0;
            cnt_q <= '0;
        end
        else
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_o = level_q;

endmodule

// [logic/pmicsc_regs.sv]
/*
 * Second status register and the two rail configuration registers, reached
 * by decoded serial commands, with rail fault routing to reset and to the
 * driver enable / interrupt pin.
 * Assumes command, state and lock inputs come from logic on ref_clk_i;
 * pins and analog comparator events are asynchronous.
 */
`timescale 1ns/1ns

// How it works
// - Status bit 2 mirrors error pin level
// - Status bit 1 latches deglitched wake rise
// - Clear latch command with 0x8E clears it
// - Entering OFF state also clears latch
// - Status bit 0 shows deglitched wake level
// - Writes only in DIAGNOSTIC with lock clear
// - Config bytes feed the configuration checksum
// - Read command returns rail config register
// - Enabled overvoltage bits cause global reset
// - Enabled undervoltage bits cause global reset
// - Cleared enable bit blocks reset
// - Enabled thermal warning pulls pin low
// - Thermal warning clears driver enable, requests SAFE
module pmicsc_regs
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic wake_pin_i,
    input wire logic mcu_err_pin_i,
    input wire logic [pmicsc_pkg::RAIL_CNT-1:0] ov_event_i,
    input wire logic [pmicsc_pkg::RAIL_CNT-1:0] uv_event_i,
    input wire logic [pmicsc_pkg::RAIL_CNT-1:0] ot_warn_i,
    input wire logic diag_state_i,
    input wire logic cfg_lock_i,
    input wire logic off_entry_i,
    input wire logic drv_en_set_i,
    input wire logic cmd_valid_i,
    input wire logic [7:0] cmd_code_i,
    input wire logic [7:0] cmd_data_i,
    output logic rd_valid_o,
    output logic [7:0] rd_data_o,
    output logic [7:0] status_two_o,
    output logic [15:0] cfg_image_o,
    output logic global_reset_o,
    output logic safe_request_o,
    output logic driver_output_enable_bit_o,
    output logic driver_enable_irq_pin_o
);
    import pmicsc_pkg::*;

    function automatic logic rail_hit(input logic [7:0] cfg, input logic [RAIL_CNT-1:0] ev,
                                      input int p_one, input int p_two, input int p_up);
        rail_hit = (cfg[p_one] & ev[0]) | (cfg[p_two] & ev[1]) | (cfg[p_up] & ev[2]);
    endfunction

    logic [ASYNC_W-1:0] async_in;
    logic [ASYNC_W-1:0] as1_q, as1_d;
    logic [ASYNC_W-1:0] as2_q, as2_d;
    logic wake_lvl;
    logic wake_prev_q, wake_prev_d;
    logic wake_l_q, wake_l_d;
    logic [7:0] rail_cfg_q, rail_cfg_d;
    logic [7:0] therm_cfg_q, therm_cfg_d;
    logic [7:0] status_q, status_d;
    logic rd_valid_q, rd_valid_d;
    logic [7:0] rd_data_q, rd_data_d;
    logic [15:0] image_q, image_d;
    logic grst_q, grst_d;
    logic safe_q, safe_d;
    logic drv_en_q, drv_en_d;
    logic wake_rise, clr_cmd, wr_ok, irq_cond;

    // ------------------------------------------------------------
    // Input synchronisers and wake filter
    // ------------------------------------------------------------
    assign async_in = {mcu_err_pin_i, ot_warn_i, uv_event_i, ov_event_i};

    always_comb
    begin
        as1_d = async_in;
        as2_d = as1_q;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            as1_q <= '0;
            as2_q <= '0;
        end
        else
        begin
            as1_q <= as1_d;
            as2_q <= as2_d;
        end
    end

    pmicsc_deglitch u_wake_dgl
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(wake_pin_i),
        .level_o(wake_lvl)
    );

    // ------------------------------------------------------------
    // Command decode and register next values
    // ------------------------------------------------------------
    assign wake_rise = wake_lvl & ~wake_prev_q;
    assign clr_cmd = cmd_valid_i && (cmd_code_i == CMD_CLR_RESUME_LATCH) && (cmd_data_i == CLR_RESUME_DATA);
    assign wr_ok = diag_state_i && (cfg_lock_i == CFG_UNLOCKED);
    assign irq_cond = rail_hit(therm_cfg_q, as2_q[ASYNC_OT_LSB +: RAIL_CNT],
                               OT_POS_ONE, OT_POS_TWO, OT_POS_STEPUP);

    always_comb
    begin
        wake_prev_d = wake_lvl;
        wake_l_d = wake_l_q;
        if (clr_cmd || off_entry_i)
        begin
            wake_l_d = 1'b0;
        end
        if (wake_rise)
        begin
            wake_l_d = 1'b1;
        end

        rail_cfg_d = rail_cfg_q;
        therm_cfg_d = therm_cfg_q;
        if (cmd_valid_i && wr_ok && (cmd_code_i == CMD_WR_RAIL_CFG))
        begin
            rail_cfg_d = cmd_data_i;
        end
        if (cmd_valid_i && wr_ok && (cmd_code_i == CMD_WR_THERM_CFG))
        begin
            therm_cfg_d = cmd_data_i & THERM_CFG_WR_MASK;
        end

        status_d = STATUS_TWO_RESET;
        status_d[STAT_ERR_BIT] = as2_q[ASYNC_ERR_POS];
        status_d[STAT_WAKE_L_BIT] = wake_l_q;
        status_d[STAT_WAKE_BIT] = wake_lvl;

        rd_valid_d = 1'b0;
        rd_data_d = rd_data_q;
        if (cmd_valid_i)
        begin
            unique case (cmd_code_i)
                CMD_RD_STATUS_TWO:
                begin
                    rd_valid_d = 1'b1;
                    rd_data_d = status_q;
                end
                CMD_RD_RAIL_CFG:
                begin
                    rd_valid_d = 1'b1;
                    rd_data_d = rail_cfg_q;
                end
                CMD_RD_THERM_CFG:
                begin
                    rd_valid_d = 1'b1;
                    rd_data_d = therm_cfg_q;
                end
                default:
                begin
                    rd_valid_d = 1'b0;
                end
            endcase
        end

        image_d = {therm_cfg_q, rail_cfg_q};

        grst_d = rail_hit(rail_cfg_q, as2_q[ASYNC_OV_LSB +: RAIL_CNT], OV_POS_ONE, OV_POS_TWO, OV_POS_STEPUP)
               | rail_hit(rail_cfg_q, as2_q[ASYNC_UV_LSB +: RAIL_CNT], UV_POS_ONE, UV_POS_TWO, UV_POS_STEPUP);

        safe_d = irq_cond;
        drv_en_d = drv_en_q;
        if (drv_en_set_i)
        begin
            drv_en_d = 1'b1;
        end
        if (irq_cond)
        begin
            drv_en_d = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wake_prev_q <= 1'b0;
            wake_l_q <= 1'b0;
            rail_cfg_q <= RAIL_CFG_RESET;
            therm_cfg_q <= THERM_CFG_RESET;
            status_q <= STATUS_TWO_RESET;
            rd_valid_q <= 1'b0;
            rd_data_q <= RD_DATA_RESET;
            image_q <= {THERM_CFG_RESET, RAIL_CFG_RESET};
            grst_q <= 1'b0;
            safe_q <= 1'b0;
            drv_en_q <= 1'b0;
        end
        else
        begin
            wake_prev_q <= wake_prev_d;
            wake_l_q <= wake_l_d;
            rail_cfg_q <= rail_cfg_d;
            therm_cfg_q <= therm_cfg_d;
            status_q <= status_d;
            rd_valid_q <= rd_valid_d;
            rd_data_q <= rd_data_d;
            image_q <= image_d;
            grst_q <= grst_d;
            safe_q <= safe_d;
            drv_en_q <= drv_en_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rd_valid_o = rd_valid_q;
    assign rd_data_o = rd_data_q;
    assign status_two_o = status_q;
    assign cfg_image_o = image_q;
    assign global_reset_o = grst_q;
    assign safe_request_o = safe_q;
    assign driver_output_enable_bit_o = drv_en_q;
    assign driver_enable_irq_pin_o = drv_en_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_wake_seen;
        wake_l_q ##1 status_two_o[STAT_WAKE_L_BIT];
    endsequence

    sequence s_irq_taken;
        safe_request_o && !driver_enable_irq_pin_o && !driver_output_enable_bit_o;
    endsequence

    a_err_mirror:
        assert property (##1 status_two_o[STAT_ERR_BIT] == $past(as2_q[ASYNC_ERR_POS]))
        else $error("status error bit does not follow pin");
    a_wake_set:
        assert property (wake_rise |=> s_wake_seen)
        else $error("wake rise not latched");
    a_wake_hold:
        assert property (wake_l_q && !clr_cmd && !off_entry_i |=> wake_l_q)
        else $error("wake latch dropped");
    a_clear_cmd:
        assert property (clr_cmd && !wake_rise |=> !wake_l_q ##1 !status_two_o[STAT_WAKE_L_BIT])
        else $error("clear command did not clear latch");
    a_clear_off:
        assert property (off_entry_i && !wake_rise |=> !wake_l_q)
        else $error("off entry did not clear latch");
    a_wake_level:
        assert property (##1 status_two_o[STAT_WAKE_BIT] == $past(wake_lvl))
        else $error("wake level bit wrong");
    a_write_block:
        assert property (!(cmd_valid_i && wr_ok) |=> $stable(rail_cfg_q) && $stable(therm_cfg_q))
        else $error("config changed without allowed write");
    a_write_take:
        assert property (cmd_valid_i && wr_ok && cmd_code_i == CMD_WR_RAIL_CFG |=> rail_cfg_q == $past(cmd_data_i))
        else $error("allowed write not stored");
    a_cksum_image:
        assert property (rail_cfg_q != $past(rail_cfg_q) |=> cfg_image_o[7:0] == $past(rail_cfg_q))
        else $error("checksum image stale");
    a_read_rail:
        assert property (cmd_valid_i && cmd_code_i == CMD_RD_RAIL_CFG |=> rd_valid_o && rd_data_o == $past(rail_cfg_q))
        else $error("rail config read wrong");
    a_rail_reset:
        assert property (|(rail_cfg_q & RAIL_OV_MASK) == 1'b0 && |(rail_cfg_q & RAIL_UV_MASK) == 1'b0
                         |=> !global_reset_o)
        else $error("reset without enable");
    a_ov_reset:
        assert property (rail_cfg_q[OV_POS_STEPUP] && as2_q[ASYNC_OV_LSB + RAIL_CNT - 1] |=> global_reset_o)
        else $error("enabled overvoltage gave no reset");
    a_safe_drop:
        assert property (!irq_cond |=> !safe_request_o)
        else $error("safe request without thermal warning");
    a_therm_block:
        assert property (~|(therm_cfg_q & THERM_CFG_WR_MASK) |=> !safe_request_o)
        else $error("safe request with thermal enables clear");
    a_drv_set:
        assert property (drv_en_set_i && !irq_cond |=> driver_output_enable_bit_o && driver_enable_irq_pin_o)
        else $error("driver enable not set");
    a_uv_reset:
        assert property (rail_cfg_q[UV_POS_ONE] && as2_q[ASYNC_UV_LSB] |=> global_reset_o)
        else $error("enabled undervoltage gave no reset");
    a_irq_safe:
        assert property (irq_cond |=> s_irq_taken)
        else $error("thermal warning not acted on");
    a_therm_resv:
        assert property ((therm_cfg_q & ~THERM_CFG_WR_MASK) == 8'h00)
        else $error("reserved thermal bits set");

endmodule

// [testbench/pmicsc_mcu_model.sv]
/*
 * Microcontroller side model: issues one decoded command per call.
 * Assumes the register slice clock; commands last one cycle.
 */
`timescale 1ns/1ns
module pmicsc_mcu_model
(
    input wire logic ref_clk_i,
    output logic cmd_valid_o,
    output logic [7:0] cmd_code_o,
    output logic [7:0] cmd_data_o
);
    initial
    begin
        cmd_valid_o = 1'b0;
        cmd_code_o = 8'hFF;
        cmd_data_o = 8'h00;
    end

    // ----------------------------------------
    // Command issue, idle lines inverted
    // ----------------------------------------
    task automatic send(input logic [7:0] code, input logic [7:0] data);
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b1;
        cmd_code_o <= code;
        cmd_data_o <= data;
        @(posedge ref_clk_i);
        cmd_valid_o <= 1'b0;
        cmd_code_o <= ~code;
        cmd_data_o <= ~data;
    endtask
endmodule

// [testbench/tb_pmic_status_config_regs.sv]
/*
 * Self-checking bench for the status and configuration register slice.
 * Assumes the package constants and a 100 MHz clock.
 */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb_pmic_status_config_regs;
    import pmicsc_pkg::*;
    logic ref_clk_i, rst_n_i, wake, err, diag, lock, off, drv_set;
    logic [2:0] ov, uv, ot;
    logic cmd_valid, rd_valid, grst, safe, drv_bit, drv_pin;
    logic [7:0] cmd_code, cmd_data, rd_data, status;
    logic [15:0] image;
    int num_errors = 0;
    int tests_run = 0;

    pmicsc_mcu_model i_pmicsc_mcu_model (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid),
        .cmd_code_o(cmd_code), .cmd_data_o(cmd_data));
    pmicsc_regs i_pmicsc_regs (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wake_pin_i(wake),
        .mcu_err_pin_i(err), .ov_event_i(ov), .uv_event_i(uv), .ot_warn_i(ot),
        .diag_state_i(diag), .cfg_lock_i(lock), .off_entry_i(off), .drv_en_set_i(drv_set),
        .cmd_valid_i(cmd_valid), .cmd_code_i(cmd_code), .cmd_data_i(cmd_data),
        .rd_valid_o(rd_valid), .rd_data_o(rd_data), .status_two_o(status),
        .cfg_image_o(image), .global_reset_o(grst), .safe_request_o(safe),
        .driver_output_enable_bit_o(drv_bit), .driver_enable_irq_pin_o(drv_pin));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    task automatic rd(input logic [7:0] code, input logic [7:0] exp);
        i_pmicsc_mcu_model.send(code, 8'h00);
        #1;
        `CHK(rd_valid, 1'b1)
        `CHK(rd_data, exp)
    endtask

    task automatic mode(input logic d, input logic l);
        @(posedge ref_clk_i);
        diag <= d;
        lock <= l;
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_values;
        rd(CMD_RD_RAIL_CFG, 8'h0B);
        rd(CMD_RD_THERM_CFG, 8'h00);
        rd(CMD_RD_STATUS_TWO, 8'h00);
        i_pmicsc_mcu_model.send(8'h55, 8'h00);
        #1;
        `CHK(rd_valid, 1'b0)
        $display("test reset_values done");
    endtask

    task automatic t_faults_default;
        @(posedge ref_clk_i);
        ov <= 3'b111;
        wait_cyc(5);
        `CHK(grst, 1'b0)
        @(posedge ref_clk_i);
        ov <= 3'b000;
        uv <= 3'b001;
        wait_cyc(5);
        `CHK(grst, 1'b1)
        @(posedge ref_clk_i);
        uv <= 3'b000;
        wait_cyc(5);
        `CHK(grst, 1'b0)
        $display("test faults_default done");
    endtask

    task automatic t_writes;
        mode(1'b0, 1'b0);
        i_pmicsc_mcu_model.send(CMD_WR_RAIL_CFG, 8'h00);
        mode(1'b1, 1'b1);
        i_pmicsc_mcu_model.send(CMD_WR_RAIL_CFG, 8'h00);
        rd(CMD_RD_RAIL_CFG, 8'h0B);
        mode(1'b1, 1'b0);
        i_pmicsc_mcu_model.send(CMD_WR_RAIL_CFG, 8'h44);
        i_pmicsc_mcu_model.send(CMD_WR_THERM_CFG, 8'hFF);
        rd(CMD_RD_RAIL_CFG, 8'h44);
        rd(CMD_RD_THERM_CFG, 8'h0B);
        wait_cyc(3);
        `CHK(image, 16'h0B44)
        $display("test writes done");
    endtask

    task automatic t_faults_written;
        i_pmicsc_mcu_model.send(CMD_WR_RAIL_CFG, 8'h80);
        @(posedge ref_clk_i);
        uv <= 3'b111;
        ov <= 3'b011;
        wait_cyc(5);
        `CHK(grst, 1'b0)
        @(posedge ref_clk_i);
        ov <= 3'b100;
        wait_cyc(5);
        `CHK(grst, 1'b1)
        @(posedge ref_clk_i);
        ov <= 3'b000;
        uv <= 3'b000;
        $display("test faults_written done");
    endtask

    task automatic t_thermal;
        i_pmicsc_mcu_model.send(CMD_WR_THERM_CFG, 8'h00);
        @(posedge ref_clk_i);
        drv_set <= 1'b1;
        ot <= 3'b111;
        @(posedge ref_clk_i);
        drv_set <= 1'b0;
        wait_cyc(5);
        `CHK({drv_bit, drv_pin, safe}, 3'b110)
        i_pmicsc_mcu_model.send(CMD_WR_THERM_CFG, 8'h02);
        wait_cyc(5);
        `CHK({drv_bit, drv_pin, safe}, 3'b001)
        @(posedge ref_clk_i);
        ot <= 3'b000;
        $display("test thermal done");
    endtask

    task automatic t_mid_reset;
        @(posedge ref_clk_i);
        rst_n_i <= 1'b0;
        wait_cyc(2);
        `CHK({grst, safe, drv_bit, drv_pin}, 4'h0)
        `CHK(image, 16'h000B)
        `CHK(status, 8'h00)
        @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        rd(CMD_RD_RAIL_CFG, 8'h0B);
        rd(CMD_RD_THERM_CFG, 8'h00);
        $display("test mid_reset done");
    endtask

    task automatic t_wake;
        @(posedge ref_clk_i);
        wake <= 1'b1;
        err <= 1'b1;
        wait_cyc(WAKE_DEGLITCH_CYC + 10);
        `CHK(status, 8'h07)
        @(posedge ref_clk_i);
        wake <= 1'b0;
        err <= 1'b0;
        wait_cyc(WAKE_DEGLITCH_CYC + 10);
        `CHK(status, 8'h02)
        i_pmicsc_mcu_model.send(CMD_CLR_RESUME_LATCH, 8'h00);
        wait_cyc(3);
        `CHK(status, 8'h02)
        i_pmicsc_mcu_model.send(CMD_CLR_RESUME_LATCH, CLR_RESUME_DATA);
        wait_cyc(3);
        `CHK(status, 8'h00)
        @(posedge ref_clk_i);
        wake <= 1'b1;
        wait_cyc(WAKE_DEGLITCH_CYC + 10);
        @(posedge ref_clk_i);
        off <= 1'b1;
        @(posedge ref_clk_i);
        off <= 1'b0;
        wait_cyc(3);
        `CHK(status, 8'h01)
        $display("test wake done");
    endtask

    // ----------------------------------------
    // Clock, reset, sequence and watchdog
    // ----------------------------------------
    initial
    begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        rst_n_i = 1'b0;
        {wake, err, diag, lock, off, drv_set} = 6'h00;
        {ov, uv, ot} = 9'h000;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset_values();
        t_faults_default();
        t_writes();
        t_faults_written();
        t_thermal();
        t_mid_reset();
        t_wake();
        give_verdict();
    end

    initial
    begin
        #200000;
        num_errors++;
        give_verdict();
    end
endmodule
